// [core/tmr8_cfg.svh]
// Register offsets, field positions, reset values and counts for the 8-bit PWM timer.
`ifndef TMR8_CFG_SVH
`define TMR8_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TMR8_OFS_CTRL1 5'h00
`define TMR8_OFS_CTRL2 5'h04
`define TMR8_OFS_COUNT 5'h08
`define TMR8_OFS_CMPA 5'h0c
`define TMR8_OFS_CMPB 5'h10
`define TMR8_OFS_FLAGS 5'h14
`define TMR8_OFS_STAT 5'h18

// ****************************************
// Field positions
// ****************************************
`define TMR8_MODEA_F 7:6
`define TMR8_MODEB_F 5:4
`define TMR8_WGMLO_F 1:0
`define TMR8_FORCEA_B 7
`define TMR8_FORCEB_B 6
`define TMR8_WGMHI_B 3
`define TMR8_CS_F 2:0
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_MA 1
`define TMR8_FLAG_MB 2

// ****************************************
// Values
// ****************************************
`define TMR8_RST8 8'h00
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_ONE 8'h01
`define TMR8_DIV_W 10
`define TMR8_DIV8_MSB 2
`define TMR8_DIV64_MSB 5
`define TMR8_DIV256_MSB 7
`define TMR8_DIV1024_MSB 9

`endif

// [core/tmr8_pkg.sv]
// Types shared by the 8-bit PWM timer modules.
package tmr8_pkg;
    typedef logic [2:0] tmr8_code_t;
    typedef enum logic [1:0] {
        TMR8_NORMAL,
        TMR8_CTC,
        TMR8_FAST,
        TMR8_PHASE
    } tmr8_kind_t;
endpackage

// [core/tmr8_tick_if.sv]
// Carrier between the timer core and its tick prescaler.
interface tmr8_tick_if;
    logic [2:0] clock_source_code;
    logic ext_pin;
    logic timer_tick_enable;
    modport pre (input clock_source_code, input ext_pin, output timer_tick_enable);
    modport core (output clock_source_code, output ext_pin, input timer_tick_enable);
endinterface

// [core/tmr8_prescale.sv]
// Prescaler that turns the clock source code into a one-cycle timer tick enable.
`include "tmr8_cfg.svh"
module tmr8_prescale
    import tmr8_pkg::*;
#(
    parameter int DIV_W = `TMR8_DIV_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Tick request and answer.
    tmr8_tick_if.pre tif
);
    logic [DIV_W-1:0] div;
    logic ext_prev;
    logic tick;

    if (DIV_W < `TMR8_DIV_W) begin : g_chk
        $error("Divider too narrow for the largest prescale.");
    end

    // The divider runs free, so a new source code may cut the first period short.
    always_ff @(posedge clk) begin
        if (srst) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= tif.ext_pin;
        end
    end

    always_comb begin
        case (tif.clock_source_code)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = &div[`TMR8_DIV8_MSB:0];
            3'h3: tick = &div[`TMR8_DIV64_MSB:0];
            3'h4: tick = &div[`TMR8_DIV256_MSB:0];
            3'h5: tick = &div[`TMR8_DIV1024_MSB:0];
            3'h6: tick = ext_prev & ~tif.ext_pin;
            3'h7: tick = ~ext_prev & tif.ext_pin;
            default: tick = 1'b0;
        endcase
    end

    assign tif.timer_tick_enable = tick;
endmodule

// [core/tmr8_pwm.sv]
// 8-bit timer with dual-slope PWM and compare output units, Avalon-MM register slave.
`include "tmr8_cfg.svh"

module tmr8_pwm
    import tmr8_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External count source.
    input wire logic ext_clk_pin,
    // Waveform outputs and pin overrides.
    output logic wave_out_a,
    output logic wave_out_a_en,
    output logic wave_out_b,
    output logic wave_out_b_en
);
    if (CNT_W != 8) begin : g_chk
        $error("Only an 8-bit counter is supported.");
    end

    // ****************************************
    // Registers
    // ****************************************
    logic [1:0] out_mode_a;
    logic [1:0] out_mode_b;
    logic [1:0] wave_mode_lo;
    logic wave_mode_high_bit;
    logic [2:0] clock_source_code;
    logic [7:0] count_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] cmp_act [2];
    logic [2:0] flags;
    logic dir_up;
    logic blk;
    logic ack;
    logic [1:0] wave;
    logic [1:0] up_done;

    logic wr;
    logic [7:0] wd;
    logic [7:0] rmux;
    tmr8_code_t wave_mode_code;
    tmr8_kind_t kind;
    logic [7:0] top;
    logic tick;
    logic at_top;
    logic at_bot;
    logic eff_up;
    logic [7:0] next_count;
    logic load_cmp;
    logic ovf_set;
    logic [1:0] match;
    logic [1:0] force_m;
    logic [1:0] conn;
    logic [1:0] om [2];

    tmr8_tick_if tif ();

    // ****************************************
    // Bus slave
    // ****************************************
    // One wait cycle lets the read data come from a register.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr = avs_write & ack;
    assign wd = avs_writedata[7:0];

    always_ff @(posedge clk) begin
        if (srst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
        end
    end

    always_comb begin
        case (avs_address)
            `TMR8_OFS_CTRL1: rmux = {out_mode_a, out_mode_b, 2'h0, wave_mode_lo};
            `TMR8_OFS_CTRL2: rmux = {4'h0, wave_mode_high_bit, clock_source_code};
            `TMR8_OFS_COUNT: rmux = count_value;
            `TMR8_OFS_CMPA: rmux = compare_a_value;
            `TMR8_OFS_CMPB: rmux = compare_b_value;
            `TMR8_OFS_FLAGS: rmux = {5'h00, flags};
            `TMR8_OFS_STAT: rmux = {5'h00, dir_up, wave};
            default: rmux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack) begin
            avs_readdata <= {24'h00_0000, rmux};
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_mode_a <= 2'h0;
            out_mode_b <= 2'h0;
            wave_mode_lo <= 2'h0;
        end else if (wr && avs_address == `TMR8_OFS_CTRL1) begin
            out_mode_a <= wd[`TMR8_MODEA_F];
            out_mode_b <= wd[`TMR8_MODEB_F];
            wave_mode_lo <= wd[`TMR8_WGMLO_F];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wave_mode_high_bit <= 1'b0;
            clock_source_code <= 3'h0;
        end else if (wr && avs_address == `TMR8_OFS_CTRL2) begin
            wave_mode_high_bit <= wd[`TMR8_WGMHI_B];
            clock_source_code <= wd[`TMR8_CS_F];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            compare_a_value <= `TMR8_RST8;
            compare_b_value <= `TMR8_RST8;
        end else if (wr && avs_address == `TMR8_OFS_CMPA) begin
            compare_a_value <= wd;
        end else if (wr && avs_address == `TMR8_OFS_CMPB) begin
            compare_b_value <= wd;
        end
    end

    // ****************************************
    // Mode decode and tick
    // ****************************************
    assign wave_mode_code = {wave_mode_high_bit, wave_mode_lo};
    assign tif.clock_source_code = clock_source_code;
    assign tif.ext_pin = ext_clk_pin;
    assign tick = tif.timer_tick_enable;

    tmr8_prescale #(.DIV_W(`TMR8_DIV_W)) u_pre (
        .clk(clk),
        .srst(srst),
        .tif(tif)
    );

    always_comb begin
        case (wave_mode_code)
            3'h1, 3'h5: kind = TMR8_PHASE;
            3'h2: kind = TMR8_CTC;
            3'h3, 3'h7: kind = TMR8_FAST;
            default: kind = TMR8_NORMAL;
        endcase
    end

    assign top = (wave_mode_code == 3'h5 || wave_mode_code == 3'h7 ||
                  wave_mode_code == 3'h2) ? cmp_act[0] : `TMR8_MAX;
    assign at_top = count_value == top;
    assign at_bot = count_value == `TMR8_BOTTOM;
    // Bottom always counts as the start of the up slope, top as the turn down.
    assign eff_up = at_bot | (dir_up & ~at_top);

    // ****************************************
    // Counter
    // ****************************************
    always_comb begin
        case (kind)
            TMR8_PHASE: begin
                if (eff_up && !at_top) begin
                    next_count = count_value + `TMR8_ONE;
                end else if (!eff_up) begin
                    next_count = count_value - `TMR8_ONE;
                end else begin
                    next_count = count_value;
                end
            end
            TMR8_FAST, TMR8_CTC: next_count = at_top ? `TMR8_BOTTOM : count_value + `TMR8_ONE;
            default: next_count = count_value + `TMR8_ONE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_value <= `TMR8_RST8;
            blk <= 1'b0;
        end else if (wr && avs_address == `TMR8_OFS_COUNT) begin
            count_value <= wd;
            blk <= 1'b1;
        end else if (tick) begin
            count_value <= next_count;
            blk <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            dir_up <= 1'b1;
        end else if (tick && kind == TMR8_PHASE) begin
            dir_up <= eff_up;
        end
    end

    // Compare values take effect at top in dual-slope, at the wrap in fast mode.
    always_comb begin
        case (kind)
            TMR8_PHASE, TMR8_FAST: load_cmp = tick & at_top;
            default: load_cmp = 1'b1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_act[0] <= `TMR8_RST8;
            cmp_act[1] <= `TMR8_RST8;
        end else if (load_cmp) begin
            cmp_act[0] <= compare_a_value;
            cmp_act[1] <= compare_b_value;
        end
    end

    // ****************************************
    // Flags
    // ****************************************
    always_comb begin
        case (kind)
            TMR8_PHASE: ovf_set = tick & at_bot;
            TMR8_FAST: ovf_set = tick & (wave_mode_high_bit ? at_top : count_value == `TMR8_MAX);
            default: ovf_set = tick & (count_value == `TMR8_MAX);
        endcase
    end

    // Writing a one clears a flag; a new event in the same cycle wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            flags <= 3'h0;
        end else begin
            flags <= (flags & ~((wr && avs_address == `TMR8_OFS_FLAGS) ? wd[2:0] : 3'h0))
                | {match[1], match[0], ovf_set};
        end
    end

    // ****************************************
    // Compare output units
    // ****************************************
    assign om[0] = out_mode_a;
    assign om[1] = out_mode_b;

    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic tog_ok;
        logic special;

        // Toggle in PWM modes exists on channel A only, and only when the mode high bit is set.
        assign tog_ok = (i == 0) & wave_mode_high_bit;
        assign special = om[i][1] & (cmp_act[i] == top);
        assign match[i] = tick & ~blk & (count_value == cmp_act[i]);
        assign force_m[i] = wr && avs_address == `TMR8_OFS_CTRL2 &&
            wd[`TMR8_FORCEA_B - i] && (kind == TMR8_NORMAL || kind == TMR8_CTC);
        assign conn[i] = (kind == TMR8_NORMAL || kind == TMR8_CTC) ? om[i] != 2'h0 :
            (om[i][1] | ((om[i] == 2'h1) & tog_ok));

        always_ff @(posedge clk) begin
            if (srst) begin
                up_done[i] <= 1'b0;
            end else if (tick && at_bot) begin
                up_done[i] <= match[i];
            end else if (match[i] && eff_up) begin
                up_done[i] <= 1'b1;
            end
        end

        always_ff @(posedge clk) begin
            if (srst) begin
                wave[i] <= 1'b0;
            end else begin
                case (kind)
                    TMR8_PHASE: begin
                        if (om[i] == 2'h1) begin
                            if (tog_ok && match[i]) begin
                                wave[i] <= ~wave[i];
                            end
                        end else if (om[i][1]) begin
                            if (tick && at_top && special) begin
                                wave[i] <= ~om[i][0];
                            end else if (tick && at_top && !up_done[i]) begin
                                wave[i] <= om[i][0];
                            end else if (match[i]) begin
                                wave[i] <= eff_up ? om[i][0] : ~om[i][0];
                            end
                        end
                    end
                    TMR8_FAST: begin
                        if (om[i] == 2'h1) begin
                            if (tog_ok && match[i]) begin
                                wave[i] <= ~wave[i];
                            end
                        end else if (om[i][1]) begin
                            if (match[i] && !special) begin
                                wave[i] <= om[i][0];
                            end else if (tick && at_top) begin
                                // The wrap to bottom and top are the same tick here.
                                wave[i] <= ~om[i][0];
                            end
                        end
                    end
                    default: begin
                        if (match[i] || force_m[i]) begin
                            case (om[i])
                                2'h1: wave[i] <= ~wave[i];
                                2'h2: wave[i] <= 1'b0;
                                2'h3: wave[i] <= 1'b1;
                                default: wave[i] <= wave[i];
                            endcase
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wave_out_a = wave[0];
    assign wave_out_b = wave[1];
    assign wave_out_a_en = conn[0];
    assign wave_out_b_en = conn[1];
endmodule

// [dv/tmr8_pwm_asserts.sv]
// Port-level assertions for the 8-bit PWM timer.
module tmr8_chk
    import tmr8_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Register bus.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins.
    input wire logic ext_clk_pin,
    input wire logic wave_out_a,
    input wire logic wave_out_a_en,
    input wire logic wave_out_b,
    input wire logic wave_out_b_en
);
    // ****
    // Shadow state
    // ****
    logic [7:0] sh [8];
    logic [3:0] idle;
    logic [11:0] steady;
    logic [9:0] gap;
    logic req;
    logic taken;
    logic full_pc;
    logic [1:0] exp_en;
    assign req = avs_read | avs_write;
    assign taken = avs_write & ~avs_waitrequest;
    // Extremes of compare A give a flat wave, so the period check leaves them out.
    assign full_pc = sh[0][7] && sh[0][1:0] == 2'h1 && sh[1][3:0] == 4'h1
        && sh[3] != 8'h00 && sh[3] != 8'hff;
    // In PWM modes code 01 reaches the pin only as channel A's toggle option.
    assign exp_en[1] = sh[0][0] ? sh[0][7] | (sh[0][7:6] == 2'h1 && sh[1][3])
        : sh[0][7:6] != 2'h0;
    assign exp_en[0] = sh[0][0] ? sh[0][5] : sh[0][5:4] != 2'h0;
    always_ff @(posedge clk) begin
        if (srst) begin
            sh <= '{default: 8'h00};
        end else if (taken && avs_address[1:0] == 2'h0) begin
            sh[avs_address[4:2]] <= avs_writedata[7:0];
        end
    end
    // A tick may lag the source change by a few cycles, hence the margin.
    always_ff @(posedge clk) begin
        if (srst || sh[1][2:0] != 3'h0 || (taken && avs_address == 5'h04)) begin
            idle <= 4'h0;
        end else if (idle != 4'hf) begin
            idle <= idle + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (srst || taken) begin
            steady <= 12'h000;
        end else if (steady != 12'hfff) begin
            steady <= steady + 12'h001;
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            gap <= 10'h000;
        end else if ($rose(wave_out_a)) begin
            gap <= 10'h001;
        end else if (gap != 10'h3ff) begin
            gap <= gap + 10'h001;
        end
    end
    // ****
    // Assertions
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence one_wait_s;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    bus_wait_a: assert property (req && !$past(req) |-> one_wait_s)
        else $error("bus wait not one cycle");
    read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address == 5'h1c
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    pin_a_override_a: assert property (wave_out_a_en == exp_en[1])
        else $error("channel a override wrong");
    pin_b_override_a: assert property (wave_out_b_en == exp_en[0])
        else $error("channel b override wrong");
    reset_low_a: assert property ($fell(srst) |-> !wave_out_a && !wave_out_b)
        else $error("wave not low after reset");
    stop_hold_a: assert property (idle > 4'h5
        |-> $stable(wave_out_a) && $stable(wave_out_b)) else $error("wave moved while stopped");
    full_period_a: assert property ($rose(wave_out_a) && full_pc && steady > 12'h640
        |-> gap == 10'h1fe) else $error("dual-slope period wrong");
endmodule

bind tmr8_pwm tmr8_chk #(.CNT_W(CNT_W)) i_chk (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_clk_pin(ext_clk_pin), .wave_out_a(wave_out_a),
    .wave_out_a_en(wave_out_a_en), .wave_out_b(wave_out_b), .wave_out_b_en(wave_out_b_en)
);

// [dv/tmr8_tb.sv]
// Self-checking bench for the 8-bit PWM timer with a tick-level model.
`include "tmr8_cfg.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_clk_pin = 1'b0;
    logic wave_out_a, wave_out_a_en, wave_out_b, wave_out_b_en;
    int errors = 0;
    int comparisons = 0;
    int cnt, dir, ovf, top, kind, frc;
    int m[2], c[2], w[2], s[2];
    logic [7:0] rd, v;
    logic [4:0] adr [6] = '{5'h00, 5'h08, 5'h0c, 5'h10, 5'h1c, 5'h04};
    logic [7:0] msk [6] = '{8'hf3, 8'hff, 8'hff, 8'hff, 8'h00, 8'h0f};

    always #10 clk = ~clk;

    tmr8_pwm i_dut (
        .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_clk_pin(ext_clk_pin), .wave_out_a(wave_out_a),
        .wave_out_a_en(wave_out_a_en), .wave_out_b(wave_out_b), .wave_out_b_en(wave_out_b_en)
    );

    // ****
    // Bus and pin drivers
    // ****
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_ack();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            errors++;
            $display("BAD %0t no bus answer", $time);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
    endtask
    task automatic rd8(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
    endtask
    // Each pulse carries one rising and one falling edge, so either edge source ticks once.
    task automatic pulse();
        @(posedge clk);
        ext_clk_pin <= 1'b1;
        repeat (3) @(posedge clk);
        ext_clk_pin <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ****
    // Model
    // ****
    function automatic int act(int code, int lvl, int up);
        if (code == 1) return 1 - lvl;
        if (code == 2) return up ? 0 : 1;
        if (code == 3) return up;
        return lvl;
    endfunction
    // Reads are made only away from edges of the count, where tick placement is unambiguous.
    function automatic bit near(int x);
        return cnt - x <= 2 && x - cnt <= 2;
    endfunction
    task automatic mstep();
        if (kind == 1) begin
            if (cnt == 0) begin
                ovf = 1;
                dir = 1;
            end
            cnt = dir ? cnt + 1 : cnt - 1;
        end else begin
            cnt = (cnt == top) ? 0 : cnt + 1;
            if (cnt == 0 && kind != 2) ovf = 1;
        end
        for (int i = 0; i < 2; i++) begin
            if (kind == 1 && cnt == top) begin
                w[i] = (c[i] == top) ? act(m[i], w[i], 0) : (s[i] ? w[i] : act(m[i], w[i], 1));
                s[i] = 0;
            end else if (kind == 3 && cnt == 0) begin
                w[i] = act(m[i], w[i], 0);
            end else if (cnt == c[i]) begin
                w[i] = act(m[i], w[i], kind == 1 ? dir : 1);
                s[i] = s[i] | dir;
            end
        end
        if (kind == 1 && cnt == top) dir = 0;
    endtask
    task automatic check_all();
        logic [7:0] mk;
        logic [7:0] e;
        mk = (kind == 1) ? ((top != 255) ? 8'h06 : 8'h07) : 8'h03;
        e = {5'h0, dir[0], w[1][0], w[0][0]};
        rd8(`TMR8_OFS_COUNT, rd);
        `CHK(rd, 8'(cnt))
        rd8(`TMR8_OFS_STAT, rd);
        `CHK(rd & mk, e & mk)
        rd8(`TMR8_OFS_FLAGS, rd);
        `CHK(rd[0], ovf[0])
        wr(`TMR8_OFS_FLAGS, 8'h07);
        ovf = 0;
    endtask
    task automatic run(int wgm, int c0, int c1, int st, int np);
        kind = (wgm == 1 || wgm == 5) ? 1 : (wgm == 7) ? 3 : wgm;
        top = (wgm == 5 || wgm == 7 || wgm == 2) ? c0 : 255;
        do_reset();
        m[0] = (kind == 0 || kind == 2) ? 1 + $urandom % 3 : 2 + $urandom % 2;
        m[1] = (kind == 0 || kind == 2) ? 1 + $urandom % 3 : 2 + $urandom % 2;
        frc = (kind == 0 || kind == 2) ? $urandom % 4 : 0;
        c = '{c0, c1};
        w = '{0, 0};
        s = '{0, 0};
        cnt = st;
        dir = 1;
        ovf = 0;
        wr(`TMR8_OFS_CMPA, 8'(c0));
        wr(`TMR8_OFS_CMPB, 8'(c1));
        wr(`TMR8_OFS_COUNT, 8'(st));
        wr(`TMR8_OFS_CTRL1, {2'(m[0]), 2'(m[1]), 2'h0, 2'(wgm)});
        wr(`TMR8_OFS_CTRL2, {2'(frc), 2'h0, 1'(wgm >> 2), 2'h3, 1'($urandom)});
        for (int i = 0; i < 2; i++) begin
            if (frc[1 - i]) w[i] = act(m[i], w[i], 1);
        end
        for (int i = 0; i < np || near(0) || near(top) || near(c[0]) || near(c[1]); i++) begin
            pulse();
            mstep();
        end
        check_all();
        wr(`TMR8_OFS_CTRL2, {4'h0, 1'(wgm >> 2), 3'h0});
        repeat (4) pulse();
        check_all();
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        void'($urandom(32'hdffe6a72));
        do_reset();
        for (int a = 0; a < 8; a++) begin
            rd8(5'(a * 4), rd);
            `CHK(rd, (a == 6) ? 8'h04 : 8'h00)
        end
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            wr(adr[i], v);
            rd8(adr[i], rd);
            `CHK(rd, v & msk[i])
        end
        run(1, 8'h40 + $urandom % 48, 8'h90 + $urandom % 48, 0, 300 + $urandom % 400);
        run(1, 8'h40 + $urandom % 48, 8'h90 + $urandom % 48, 8'hd0, 200 + $urandom % 400);
        run(5, 8'hc0 + $urandom % 32, 8'h50 + $urandom % 48, 0, 400 + $urandom % 400);
        run(0, 8'h30 + $urandom % 64, 8'h90 + $urandom % 64, 0, 300 + $urandom % 400);
        run(3, 8'h30 + $urandom % 64, 8'h90 + $urandom % 64, 0, 300 + $urandom % 400);
        run(1, 255, 8'h60 + $urandom % 64, 0, 600);
        run(2, 8'h90 + $urandom % 48, 8'h30 + $urandom % 64, 0, 300 + $urandom % 400);
        run(7, 8'hc0 + $urandom % 32, 8'h40 + $urandom % 64, 0, 300 + $urandom % 400);
        do_reset();
        wr(`TMR8_OFS_CMPA, 8'h80);
        wr(`TMR8_OFS_CTRL1, 8'h81);
        wr(`TMR8_OFS_CTRL2, 8'h01);
        repeat (2400) @(posedge clk);
        rd8(`TMR8_OFS_FLAGS, rd);
        `CHK(rd[0], 1'b1)
        tally_and_finish();
    end
    initial begin
        #2000000;
        errors++;
        $display("BAD %0t watchdog", $time);
        tally_and_finish();
    end
endmodule
